/* hdl/ccsr_pkg.sv */
package ccsr_pkg;
  // Number of clock domains and how many of them sit in the isolated area
  localparam int CCSR_NDOM = 4;
  localparam int CCSR_NISO = 2;
  // Register byte offsets on the software port
  localparam logic [7:0] CCSR_OFS_MAIN_OSC = 8'h00;
  localparam logic [7:0] CCSR_OFS_FAST_RC = 8'h04;
  localparam logic [7:0] CCSR_OFS_PLL = 8'h08;
  localparam logic [7:0] CCSR_OFS_STATUS = 8'h0c;
  localparam logic [7:0] CCSR_OFS_SEL0 = 8'h10;
  localparam logic [7:0] CCSR_SEL_STEP = 8'h04;
  // Generator control fields
  localparam int CCSR_B_EN_TRG = 0;
  localparam int CCSR_B_DIS_TRG = 1;
  localparam int CCSR_B_STPMK = 2;
  localparam int CCSR_B_RUN = 3;
  // Selector fields
  localparam int CCSR_SEL_W = 3;
  localparam int CCSR_B_SEL_STPMK = 3;
  localparam int CCSR_B_SEL_RUN = 4;
  // Status fields
  localparam int CCSR_B_ST_SLOW = 0;
  localparam int CCSR_B_ST_FAST = 1;
  localparam int CCSR_B_ST_MAIN = 2;
  localparam int CCSR_B_ST_PLL = 3;
  localparam int CCSR_B_ST_GAIN = 4;
  // Reset values
  localparam logic CCSR_RST_MAIN_EN = 1'b0;
  localparam logic CCSR_RST_FAST_EN = 1'b1;
  localparam logic CCSR_RST_PLL_EN = 1'b0;
  localparam logic CCSR_RST_MASK = 1'b0;
  localparam logic [31:0] CCSR_RD_ZERO = 32'h0000_0000;

  // Selector sources; divided codes are prescaler outputs, crystal is never divided
  typedef enum logic [CCSR_SEL_W-1:0] {
    CCSR_SRC_FAST_RC = 3'b000,
    CCSR_SRC_FAST_RC_DIV = 3'b001,
    CCSR_SRC_SLOW_RC = 3'b010,
    CCSR_SRC_SLOW_RC_DIV = 3'b011,
    CCSR_SRC_CRYSTAL = 3'b100,
    CCSR_SRC_PLL = 3'b101,
    CCSR_SRC_PLL_DIV = 3'b110
  } ccsr_src_t;
  localparam ccsr_src_t CCSR_SRC_DEFAULT = CCSR_SRC_FAST_RC;

  // Generator control bits kept per generator
  typedef struct packed {
    logic en;
    logic mask;
  } ccsr_gen_t;

  // Per-domain selector state
  typedef struct packed {
    ccsr_src_t src;
    logic mask;
    logic run;
    logic clk;
  } ccsr_dom_t;
endpackage

/* hdl/ccsr_if.sv */
`timescale 1ns/100ps
interface ccsr_if;
  logic power_up_reset; // Power-up reset level
  logic system_reset; // Any reset source level
  logic ext_reset; // External reset pin level
  logic standby_stop_request; // Stop request level
  logic deep_power_down_mode_wakeup_reset; // Deep-stop wake-up pulse
  logic wakeup_osc_start; // Crystal start on wake-up pulse
  logic main_osc_active; // Crystal running, back to stand-by side

  modport dev (
    input power_up_reset, system_reset, ext_reset, standby_stop_request,
    input deep_power_down_mode_wakeup_reset, wakeup_osc_start,
    output main_osc_active
  );
  modport ctl (
    output power_up_reset, system_reset, ext_reset, standby_stop_request,
    output deep_power_down_mode_wakeup_reset, wakeup_osc_start,
    input main_osc_active
  );
endinterface

/* hdl/ccsr_stbc.sv */
`timescale 1ns/100ps
module ccsr_stbc (
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  ccsr_if.ctl bus, // Link to the clock controller
  input wire logic por_req, // Power-up reset request
  input wire logic ext_rst_req, // External reset pin request
  input wire logic int_rst_req, // Other internal reset request
  input wire logic stop_req, // Enter ordinary stop mode
  input wire logic deep_req, // Enter deep-stop mode
  input wire logic wake_osc_req, // Start crystal on next wake-up
  output logic standby_active, // Stop request being driven
  output logic crystal_seen // Crystal activity from controller
);
  import ccsr_pkg::*;

  typedef struct packed {
    logic por;
    logic sys;
    logic ext;
    logic stop;
    logic deep;
    logic dpwu;
    logic wuosc;
  } ccsr_stbc_st_t;

  ccsr_stbc_st_t s_q, s_d;

  // Next state: levels follow requests, wake-up events become one-cycle pulses
  always_comb begin
    s_d = s_q;
    s_d.por = por_req;
    s_d.sys = por_req | ext_rst_req | int_rst_req;
    s_d.ext = ext_rst_req;
    s_d.stop = stop_req | deep_req;
    s_d.deep = deep_req;
    // Deep-stop release resets the isolated selectors
    s_d.dpwu = s_q.deep & ~deep_req;
    // Optional crystal start as the stop request drops
    s_d.wuosc = s_q.stop & ~s_d.stop & wake_osc_req;
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign bus.power_up_reset = s_q.por;
  assign bus.system_reset = s_q.sys;
  assign bus.ext_reset = s_q.ext;
  assign bus.standby_stop_request = s_q.stop;
  assign bus.deep_power_down_mode_wakeup_reset = s_q.dpwu;
  assign bus.wakeup_osc_start = s_q.wuosc;
  assign standby_active = s_q.stop;
  assign crystal_seen = bus.main_osc_active;
endmodule

/* hdl/ccsr_ctrl.sv */
`timescale 1ns/100ps
module ccsr_ctrl #(
  parameter logic [ccsr_pkg::CCSR_NDOM-1:0] HAS_STPMK = 4'b0111 // Selectors with a stop mask
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  ccsr_if.dev bus, // Reset and stand-by control signals
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after strobe
  output logic slow_rc_run, // Slow RC oscillator enable
  output logic fast_rc_run, // Fast RC oscillator enable
  output logic main_osc_run, // Crystal oscillator enable
  output logic main_osc_gain_max, // Crystal amplifier at full gain
  output logic pll_run, // PLL enable
  output logic pll_reference_input, // Crystal clock offered as PLL reference
  output ccsr_pkg::ccsr_src_t domain_src [ccsr_pkg::CCSR_NDOM], // Chosen source per domain
  output logic [ccsr_pkg::CCSR_NDOM-1:0] domain_clock // Domain clocks
);
  import ccsr_pkg::*;

  typedef struct packed {
    ccsr_gen_t main;
    ccsr_gen_t fast;
    ccsr_gen_t pll;
    ccsr_dom_t [CCSR_NDOM-1:0] dom;
    logic [31:0] rdata;
  } ccsr_ctrl_st_t;

  ccsr_ctrl_st_t s_q, s_d;
  logic stop; // Stop request as seen by the generators
  logic main_on, fast_on, pll_on; // Generator outputs running
  logic [CCSR_NDOM-1:0] src_ok; // Selected source running
  logic [CCSR_NDOM-1:0] want_run; // Domain should be clocking

  // Stop request goes to crystal, fast RC and PLL, deep-stop included; slow RC ignores it
  assign stop = bus.standby_stop_request;

  // Enable bits are untouched by stand-by, so an unmasked stop only pauses
  // the generator and it resumes on wake-up when enabled; deep-stop wake-up clears the PLL enable, wake-up crystal start sets the crystal enable.
  always_comb begin
    main_on = s_q.main.en & ~(stop & ~s_q.main.mask);
    fast_on = s_q.fast.en & ~(stop & ~s_q.fast.mask);
    // PLL needs the crystal as its reference
    pll_on = s_q.pll.en & main_on & ~(stop & ~s_q.pll.mask);
  end

  // Source availability and stop decision per selector
  generate
    for (genvar i = 0; i < CCSR_NDOM; i++) begin : g_avail
      always_comb begin
        unique case (s_q.dom[i].src)
          CCSR_SRC_FAST_RC, CCSR_SRC_FAST_RC_DIV: src_ok[i] = fast_on;
          CCSR_SRC_SLOW_RC, CCSR_SRC_SLOW_RC_DIV: src_ok[i] = 1'b1;
          CCSR_SRC_CRYSTAL: src_ok[i] = main_on;
          CCSR_SRC_PLL, CCSR_SRC_PLL_DIV: src_ok[i] = pll_on;
          default: src_ok[i] = 1'b0;
        endcase
        // Mask absent: stop request has no effect
        if (HAS_STPMK[i]) begin
          want_run[i] = src_ok[i] & ~(stop & ~s_q.dom[i].mask);
        end else begin
          want_run[i] = src_ok[i];
        end
      end
    end
  endgenerate

  // Next state: software port, wake-up events, domain clock phases
  always_comb begin
    logic [31:0] rd_v;
    logic [7:0] sel_ofs;
    rd_v = CCSR_RD_ZERO;
    sel_ofs = 8'h00;
    s_d = s_q;

    // Software writes to generator control
    if (wr) begin
      unique case (addr)
        CCSR_OFS_MAIN_OSC: begin
          if (wdata[CCSR_B_EN_TRG]) s_d.main.en = 1'b1;
          if (wdata[CCSR_B_DIS_TRG]) s_d.main.en = 1'b0;
          s_d.main.mask = wdata[CCSR_B_STPMK];
        end
        CCSR_OFS_FAST_RC: begin
          if (wdata[CCSR_B_EN_TRG]) s_d.fast.en = 1'b1;
          if (wdata[CCSR_B_DIS_TRG]) s_d.fast.en = 1'b0;
          s_d.fast.mask = wdata[CCSR_B_STPMK];
        end
        CCSR_OFS_PLL: begin
          if (wdata[CCSR_B_EN_TRG]) s_d.pll.en = 1'b1;
          if (wdata[CCSR_B_DIS_TRG]) s_d.pll.en = 1'b0;
          s_d.pll.mask = wdata[CCSR_B_STPMK];
        end
        default: begin
          // Selector registers; unknown source codes are refused
          for (int i = 0; i < CCSR_NDOM; i++) begin
            sel_ofs = CCSR_OFS_SEL0 + 8'(i * CCSR_SEL_STEP);
            if (addr == sel_ofs) begin
              if (wdata[CCSR_SEL_W-1:0] != {CCSR_SEL_W{1'b1}}) begin
                s_d.dom[i].src = ccsr_src_t'(wdata[CCSR_SEL_W-1:0]);
              end
              s_d.dom[i].mask = wdata[CCSR_B_SEL_STPMK] & HAS_STPMK[i];
            end
          end
        end
      endcase
    end

    // Wake-up start wins over a same-cycle software disable
    if (bus.wakeup_osc_start) begin
      s_d.main.en = 1'b1;
    end

    // Deep-stop wake-up: PLL and isolated selectors come back at reset values
    if (bus.deep_power_down_mode_wakeup_reset) begin
      s_d.pll.en = CCSR_RST_PLL_EN;
      s_d.pll.mask = CCSR_RST_MASK;
      for (int i = 0; i < CCSR_NISO; i++) begin
        s_d.dom[i].src = CCSR_SRC_DEFAULT;
        s_d.dom[i].mask = CCSR_RST_MASK;
      end
    end

    // Stop only after a full high phase, start only from low: no runt pulses
    for (int i = 0; i < CCSR_NDOM; i++) begin
      if (s_q.dom[i].run) begin
        s_d.dom[i].clk = ~s_q.dom[i].clk;
        if (!want_run[i] && s_q.dom[i].clk) begin
          s_d.dom[i].run = 1'b0;
          s_d.dom[i].clk = 1'b0;
        end
      end else begin
        s_d.dom[i].clk = 1'b0;
        s_d.dom[i].run = want_run[i];
      end
    end

    // System reset: PLL and every selector back to defaults
    if (bus.system_reset) begin
      s_d.pll.en = CCSR_RST_PLL_EN;
      s_d.pll.mask = CCSR_RST_MASK;
      for (int i = 0; i < CCSR_NDOM; i++) begin
        s_d.dom[i].src = CCSR_SRC_DEFAULT;
        s_d.dom[i].mask = CCSR_RST_MASK;
      end
    end

    // Only power-up reset touches crystal and fast RC; fast RC restarts
    if (bus.power_up_reset) begin
      s_d.main.en = CCSR_RST_MAIN_EN;
      s_d.main.mask = CCSR_RST_MASK;
      s_d.fast.en = CCSR_RST_FAST_EN;
      s_d.fast.mask = CCSR_RST_MASK;
    end

    // Read data, valid the cycle after the strobe
    if (rd) begin
      unique case (addr)
        CCSR_OFS_MAIN_OSC: begin
          rd_v[CCSR_B_EN_TRG] = s_q.main.en;
          rd_v[CCSR_B_STPMK] = s_q.main.mask;
          rd_v[CCSR_B_RUN] = main_on;
        end
        CCSR_OFS_FAST_RC: begin
          rd_v[CCSR_B_EN_TRG] = s_q.fast.en;
          rd_v[CCSR_B_STPMK] = s_q.fast.mask;
          rd_v[CCSR_B_RUN] = fast_on;
        end
        CCSR_OFS_PLL: begin
          rd_v[CCSR_B_EN_TRG] = s_q.pll.en;
          rd_v[CCSR_B_STPMK] = s_q.pll.mask;
          rd_v[CCSR_B_RUN] = pll_on;
        end
        CCSR_OFS_STATUS: begin
          rd_v[CCSR_B_ST_SLOW] = 1'b1;
          rd_v[CCSR_B_ST_FAST] = fast_on;
          rd_v[CCSR_B_ST_MAIN] = main_on;
          rd_v[CCSR_B_ST_PLL] = pll_on;
          rd_v[CCSR_B_ST_GAIN] = bus.ext_reset;
        end
        default: begin
          for (int i = 0; i < CCSR_NDOM; i++) begin
            sel_ofs = CCSR_OFS_SEL0 + 8'(i * CCSR_SEL_STEP);
            if (addr == sel_ofs) begin
              rd_v[CCSR_SEL_W-1:0] = s_q.dom[i].src;
              rd_v[CCSR_B_SEL_STPMK] = s_q.dom[i].mask;
              rd_v[CCSR_B_SEL_RUN] = s_q.dom[i].run;
            end
          end
        end
      endcase
    end
    s_d.rdata = rd_v;
  end

  // State register; software reset mirrors power-up defaults
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q.main <= '{en: CCSR_RST_MAIN_EN, mask: CCSR_RST_MASK};
      s_q.fast <= '{en: CCSR_RST_FAST_EN, mask: CCSR_RST_MASK};
      s_q.pll <= '{en: CCSR_RST_PLL_EN, mask: CCSR_RST_MASK};
      for (int i = 0; i < CCSR_NDOM; i++) begin
        s_q.dom[i] <= '{src: CCSR_SRC_DEFAULT, mask: CCSR_RST_MASK, run: 1'b0, clk: 1'b0};
      end
      s_q.rdata <= CCSR_RD_ZERO;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Generator controls; external reset keeps crystal up at full gain
  assign slow_rc_run = 1'b1;
  assign fast_rc_run = fast_on;
  assign main_osc_run = main_on | bus.ext_reset;
  assign main_osc_gain_max = bus.ext_reset;
  assign pll_run = pll_on;
  assign pll_reference_input = main_osc_run;
  assign bus.main_osc_active = main_on;
  assign rdata = s_q.rdata;

  generate
    for (genvar i = 0; i < CCSR_NDOM; i++) begin : g_out
      assign domain_src[i] = s_q.dom[i].src;
      assign domain_clock[i] = s_q.dom[i].clk;
    end
  endgenerate
endmodule

/* sim/ccsr_monitor.sv */
`timescale 1ns/100ps
// Watches link levels against the generator enables
module ccsr_monitor (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic power_up_reset, // Power-up reset
  input wire logic system_reset, // Any reset
  input wire logic ext_reset, // Pin reset
  input wire logic standby_stop_request, // Stop request
  input wire logic wakeup_osc_start, // Crystal start pulse
  input wire logic slow_rc_run, // Slow RC on
  input wire logic fast_rc_run, // Fast RC on
  input wire logic main_osc_run, // Crystal on
  input wire logic main_osc_gain_max, // Full gain
  input wire logic pll_run, // PLL on
  input wire logic pll_reference_input // PLL reference
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_slow;
    slow_rc_run;
  endproperty
  a_slow: assert property (p_slow) else $error("slow rc stopped");
  property p_gain;
    main_osc_gain_max == ext_reset;
  endproperty
  a_gain: assert property (p_gain) else $error("gain wrong");
  property p_ext;
    $rose(ext_reset) |-> main_osc_run;
  endproperty
  a_ext: assert property (p_ext) else $error("crystal off in pin reset");
  property p_ref;
    pll_reference_input == main_osc_run;
  endproperty
  a_ref: assert property (p_ref) else $error("reference wrong");
  property p_pll_ref;
    pll_run |-> main_osc_run;
  endproperty
  a_pll_ref: assert property (p_pll_ref) else $error("pll without ref");
  property p_pll_sys;
    ce && system_reset |=> !pll_run;
  endproperty
  a_pll_sys: assert property (p_pll_sys) else $error("pll kept");
  property p_pur_main;
    ce && power_up_reset |=> !main_osc_run || ext_reset;
  endproperty
  a_pur_main: assert property (p_pur_main) else $error("crystal on");
  // Fast RC must be live in the first cycle after power-up reset
  property p_pur_fast;
    ce && power_up_reset ##1 !power_up_reset && !standby_stop_request |-> fast_rc_run;
  endproperty
  a_pur_fast: assert property (p_pur_fast) else $error("fast rc off");
  property p_wake;
    ce && wakeup_osc_start && !power_up_reset |=> main_osc_run || standby_stop_request;
  endproperty
  a_wake: assert property (p_wake) else $error("crystal not started");
endmodule

/* sim/ccsr_tb_top.sv */
`timescale 1ns/100ps
// Stand-by side and clock controller joined by the link
module ccsr_tb_top;
  import ccsr_pkg::*;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
  logic clk, reset_n, ce; // Clock, reset, enable
  logic por_req, ext_rst_req, int_rst_req, stop_req, deep_req, wake_osc_req; // Requests
  logic [7:0] addr; // Register address
  logic [31:0] wdata, rdata; // Register data
  logic wr, rd; // Strobes
  logic slow_rc_run, fast_rc_run, main_osc_run, gain, pll_run, pll_ref; // Generators
  logic standby_active, crystal_seen; // Stand-by side status
  ccsr_src_t dsrc [CCSR_NDOM]; // Domain sources
  logic [CCSR_NDOM-1:0] dclk, d1; // Domain clocks, last sample
  int num_errors, comparisons, cycles; // Bookkeeping
  ccsr_if i_ccsr_if();
  ccsr_stbc i_ccsr_stbc (.clk(clk), .reset_n(reset_n), .ce(ce), .bus(i_ccsr_if.ctl),
    .por_req(por_req), .ext_rst_req(ext_rst_req), .int_rst_req(int_rst_req),
    .stop_req(stop_req), .deep_req(deep_req), .wake_osc_req(wake_osc_req),
    .standby_active(standby_active), .crystal_seen(crystal_seen));
  ccsr_ctrl i_ccsr_ctrl (.clk(clk), .reset_n(reset_n), .ce(ce), .bus(i_ccsr_if.dev),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .slow_rc_run(slow_rc_run),
    .fast_rc_run(fast_rc_run), .main_osc_run(main_osc_run), .main_osc_gain_max(gain),
    .pll_run(pll_run), .pll_reference_input(pll_ref), .domain_src(dsrc), .domain_clock(dclk));
  ccsr_monitor i_ccsr_monitor (.clk(clk), .reset_n(reset_n), .ce(ce),
    .power_up_reset(i_ccsr_if.power_up_reset), .system_reset(i_ccsr_if.system_reset),
    .ext_reset(i_ccsr_if.ext_reset), .standby_stop_request(i_ccsr_if.standby_stop_request),
    .wakeup_osc_start(i_ccsr_if.wakeup_osc_start), .slow_rc_run(slow_rc_run),
    .fast_rc_run(fast_rc_run), .main_osc_run(main_osc_run), .main_osc_gain_max(gain),
    .pll_run(pll_run), .pll_reference_input(pll_ref));
  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far above the roughly 160 cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // Domains in e must toggle, the others sit low
  task automatic dom_chk(input logic [CCSR_NDOM-1:0] e);
    cyc(1);
    d1 = dclk;
    cyc(1);
    `CHK(d1 ^ dclk, e)
    `CHK(dclk & ~e, 4'h0)
  endtask
  initial begin
    {ce, reset_n, wr, rd, addr, wdata} = {1'b1, 1'b0, 42'h0};
    {por_req, ext_rst_req, int_rst_req, stop_req, deep_req, wake_osc_req} = 6'h0;
    {num_errors, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    cyc(2);
    `CHK(slow_rc_run, 1'b1)
    rd_chk(CCSR_OFS_MAIN_OSC, 32'h0);
    rd_chk(CCSR_OFS_FAST_RC, 32'h9);
    rd_chk(CCSR_OFS_STATUS, 32'h3);
    for (int i = 0; i < CCSR_NDOM; i++) begin
      rd_chk(CCSR_OFS_SEL0 + CCSR_SEL_STEP * 8'(i), 32'h10);
    end
    wr_reg(8'h40, 32'h5);
    rd_chk(8'h40, 32'h0);
    wr_reg(CCSR_OFS_MAIN_OSC, 32'h1);
    wr_reg(CCSR_OFS_PLL, 32'h1);
    wr_reg(CCSR_OFS_SEL0, 32'h4);
    // Divided sources, refused code 7, mask on a maskless selector
    wr_reg(CCSR_OFS_SEL0 + 8'h4, 32'h6);
    wr_reg(CCSR_OFS_SEL0 + 8'h4, 32'hf);
    wr_reg(CCSR_OFS_SEL0 + 8'hc, 32'hb);
    rd_chk(CCSR_OFS_STATUS, 32'hf);
    rd_chk(CCSR_OFS_SEL0, 32'h14);
    rd_chk(CCSR_OFS_SEL0 + 8'h4, 32'h1e);
    rd_chk(CCSR_OFS_SEL0 + 8'hc, 32'h13);
    // Internal reset: generators kept, PLL and selectors cleared
    @(posedge clk) int_rst_req <= 1'b1;
    cyc(2);
    @(posedge clk) int_rst_req <= 1'b0;
    cyc(2);
    rd_chk(CCSR_OFS_MAIN_OSC, 32'h9);
    rd_chk(CCSR_OFS_PLL, 32'h0);
    rd_chk(CCSR_OFS_SEL0, 32'h10);
    rd_chk(CCSR_OFS_SEL0 + 8'h4, 32'h10);
    // Stop with crystal masked, domain 1 masked, domain 3 maskless
    wr_reg(CCSR_OFS_MAIN_OSC, 32'h5);
    wr_reg(CCSR_OFS_PLL, 32'h1);
    wr_reg(CCSR_OFS_SEL0, 32'h2);
    wr_reg(CCSR_OFS_SEL0 + 8'h4, 32'ha);
    wr_reg(CCSR_OFS_SEL0 + 8'hc, 32'h2);
    @(posedge clk) stop_req <= 1'b1;
    cyc(5);
    `CHK({main_osc_run, fast_rc_run, pll_run}, 3'b100)
    dom_chk(4'b1010);
    @(posedge clk) stop_req <= 1'b0;
    cyc(3);
    `CHK({main_osc_run, fast_rc_run, pll_run}, 3'b111)
    dom_chk(4'b1111);
    // Crystal off before stop stays off, pin reset forces it on
    wr_reg(CCSR_OFS_MAIN_OSC, 32'h2);
    @(posedge clk) stop_req <= 1'b1;
    cyc(3);
    @(posedge clk) stop_req <= 1'b0;
    cyc(3);
    `CHK(main_osc_run, 1'b0)
    @(posedge clk) ext_rst_req <= 1'b1;
    cyc(3);
    `CHK({gain, main_osc_run}, 2'b11)
    @(posedge clk) ext_rst_req <= 1'b0;
    @(posedge clk) stop_req <= 1'b1;
    cyc(3);
    @(posedge clk);
    stop_req <= 1'b0;
    wake_osc_req <= 1'b1;
    @(posedge clk) wake_osc_req <= 1'b0;
    cyc(3);
    `CHK({main_osc_run, crystal_seen}, 2'b11)
    // Deep stop clears PLL and isolated selectors only
    wr_reg(CCSR_OFS_PLL, 32'h1);
    wr_reg(CCSR_OFS_SEL0, 32'h2);
    wr_reg(CCSR_OFS_SEL0 + 8'h8, 32'h2);
    @(posedge clk) deep_req <= 1'b1;
    cyc(3);
    `CHK({standby_active, pll_run}, 2'b10)
    @(posedge clk) deep_req <= 1'b0;
    cyc(4);
    rd_chk(CCSR_OFS_PLL, 32'h0);
    rd_chk(CCSR_OFS_SEL0, 32'h10);
    rd_chk(CCSR_OFS_SEL0 + 8'h8, 32'h12);
    `CHK(dsrc[0], CCSR_SRC_DEFAULT)
    rd_chk(CCSR_OFS_MAIN_OSC, 32'h9);
    // Clock enable low: one cycle later the domain clocks must not have moved
    @(posedge clk) ce <= 1'b0;
    cyc(1);
    d1 = dclk;
    cyc(1);
    `CHK(dclk, d1)
    @(posedge clk) ce <= 1'b1;
    // Fast RC off and masked, so power-up reset has something to undo
    wr_reg(CCSR_OFS_FAST_RC, 32'h6);
    rd_chk(CCSR_OFS_FAST_RC, 32'h4);
    // Power-up reset restores generator defaults
    @(posedge clk) por_req <= 1'b1;
    cyc(2);
    @(posedge clk) por_req <= 1'b0;
    cyc(3);
    rd_chk(CCSR_OFS_MAIN_OSC, 32'h0);
    rd_chk(CCSR_OFS_FAST_RC, 32'h9);
    give_verdict();
  end
endmodule
